/* hw/link_enable_mem.sv */
// Purpose: per-link interrupt enable words with registered read port
// Assumes: one write port from the host decoder
// Notes:   all words also visible in parallel for interrupt gating
`default_nettype none
module link_enable_mem (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_wr,
  input  wire logic [3:0]                i_waddr,
  input  wire logic [11:0]               i_wdata,
  input  wire logic [3:0]                i_raddr,
  output var  logic [11:0]               o_rdata,
  output var  logic [16*12-1:0]          o_all
);
  typedef struct packed {
    logic [15:0][11:0] words;
    logic [11:0]       rdata;
  } mem_s;

  mem_s st_r;
  mem_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (i_wr)
      st_nxt.words[i_waddr] = i_wdata;
    st_nxt.rdata = st_r.words[i_raddr];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_rdata = st_r.rdata;
  assign o_all   = st_r.words;
endmodule : link_enable_mem
`default_nettype wire

/* hw/stats_counter_access_irq.sv */
// Purpose: host register bank for overflow flags, counter window, irq masks
// Assumes: asynchronous 16-bit host strobes, address/data stable in strobe
// Notes:   counters live outside; reached by a request/acknowledge port
`default_nettype none
module stats_counter_access_irq (
  input  wire logic                       i_clk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_rd_n,
  input  wire logic                       i_wr_n,
  input  wire logic [11:0]                i_addr,
  input  wire logic [15:0]                i_data,
  output var  logic [15:0]                o_data,
  output var  logic                       o_data_oe,
  output var  logic                       o_irq_n,
  input  wire logic [8*5-1:0]             i_grp_ovf_set,
  input  wire logic [15:0]                i_delay_sync_loss_end,
  input  wire logic [15:0]                i_frame_loss_end,
  input  wire logic [15:0]                i_tc_ovf_pending,
  output var  stats_irq_pkg::cnt_req_s    o_cnt,
  input  wire logic                       i_cnt_ack,
  input  wire logic [31:0]                i_cnt_rdata
);
  typedef struct packed {
    logic [2:0]  rd_sync;
    logic [2:0]  wr_sync;
    logic [1:0][11:0] addr_sync;
    logic [1:0][15:0] data_sync;
    logic        rd_pend;
    stats_irq_pkg::bus_word_s bus;
    logic [15:0] dout;
    logic        oe;
    logic [7:0]  top_hold;
    logic [15:0] mid_hold;
    logic [31:0] cnt_read;
    logic [8:0]  sel;
    logic        cmd_dir;
    logic [1:0]  cmd_code;
    logic        done;
    logic [15:0] master_mask;
    logic [15:0] tc_mask;
    stats_irq_pkg::cnt_req_s cnt;
    logic        irq_n;
  } bank_s;

  bank_s st_r;
  bank_s st_nxt;

  logic [8*5-1:0]   grp_flags;
  logic [16*2-1:0]  alarm_flags;
  logic [16*2-1:0]  alarm_set;
  logic [16*12-1:0] link_en;
  logic [11:0]      en_rdata;
  logic             rd_edge;
  logic             wr_edge;
  logic             grp_wr;
  logic             alarm_wr;
  logic             en_wr;
  logic [3:0]       wr_idx;
  logic [15:0]      link_src;
  logic [15:0]      alarm_src;
  logic [15:0]      tc_src;
  logic [11:0]      host_addr;
  logic [15:0]      host_data;
  logic             wr_grp_hit;
  logic             wr_alarm_hit;
  logic             wr_en_hit;
  logic             rd_grp_hit;
  logic             rd_alarm_hit;
  logic             rd_en_hit;

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] base,
                                    input logic [11:0] cnt);
    return (a >= base) && (a < 12'(base + cnt));
  endfunction : in_range

  function automatic logic [3:0] offset4(input logic [11:0] a,
                                         input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[3:0];
  endfunction : offset4

  // address and data are pins too: two flops, matching the two strobe
  // stages ahead of the edge detect, so both are settled at the strobe edge
  assign host_addr = st_r.addr_sync[1];
  assign host_data = st_r.data_sync[1];

  // only the second and third stages are looked at
  assign rd_edge = st_r.rd_sync[1] & ~st_r.rd_sync[2];
  assign wr_edge = st_r.wr_sync[1] & ~st_r.wr_sync[2];

  // decoded once per side; reads use the captured address
  assign wr_grp_hit   = in_range(host_addr, stats_irq_pkg::GRP_OFS,
                                 12'h008);
  assign wr_alarm_hit = in_range(host_addr, stats_irq_pkg::ALARM_OFS,
                                 12'h010);
  assign wr_en_hit    = in_range(host_addr, stats_irq_pkg::LINK_EN_OFS,
                                 12'h010);
  assign rd_grp_hit   = in_range(st_r.bus.addr, stats_irq_pkg::GRP_OFS,
                                 12'h008);
  assign rd_alarm_hit = in_range(st_r.bus.addr, stats_irq_pkg::ALARM_OFS,
                                 12'h010);
  assign rd_en_hit    = in_range(st_r.bus.addr, stats_irq_pkg::LINK_EN_OFS,
                                 12'h010);

  assign grp_wr   = wr_edge & wr_grp_hit;
  assign alarm_wr = wr_edge & wr_alarm_hit;
  assign en_wr    = wr_edge & wr_en_hit;
  assign wr_idx   = wr_grp_hit
                  ? offset4(host_addr, stats_irq_pkg::GRP_OFS)
                  : wr_alarm_hit
                  ? offset4(host_addr, stats_irq_pkg::ALARM_OFS)
                  : offset4(host_addr, stats_irq_pkg::LINK_EN_OFS);

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      alarm_set[i*2+1] = i_delay_sync_loss_end[i];
      alarm_set[i*2]   = i_frame_loss_end[i];
    end
  end

  sticky_flag_bank #(
    .N (8),
    .W (5)
  ) u_grp_flags (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_set    (i_grp_ovf_set),
    .i_wr     (grp_wr),
    .i_idx    (wr_idx),
    .i_wdata  (host_data[4:0]),
    .o_flags  (grp_flags)
  );

  sticky_flag_bank #(
    .N (16),
    .W (2)
  ) u_alarm_flags (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_set    (alarm_set),
    .i_wr     (alarm_wr),
    .i_idx    (wr_idx),
    .i_wdata  (host_data[stats_irq_pkg::SYNC_END_BIT:
                      stats_irq_pkg::FRAME_END_BIT]),
    .o_flags  (alarm_flags)
  );

  link_enable_mem u_link_en (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_wr     (en_wr),
    .i_waddr  (wr_idx),
    .i_wdata  (host_data[11:0]),
    // live address: the word is registered by the capture edge
    .i_raddr  (offset4(host_addr, stats_irq_pkg::LINK_EN_OFS)),
    .o_rdata  (en_rdata),
    .o_all    (link_en)
  );

  // per-link master status: enabled alarms, tc overflow, group flags on 0
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      alarm_src[i] = |(alarm_flags[i*2 +: 2]
                       & link_en[i*12+10 +: 2]);
      tc_src[i]    = i_tc_ovf_pending[i] & st_r.tc_mask[i];
    end
    link_src    = alarm_src | tc_src;
    link_src[0] = link_src[0] | (|grp_flags);
  end

  always_comb
  begin
    logic [3:0]  li;
    logic [15:0] rv;
    li = '0;
    rv = stats_irq_pkg::REG_RESET;
    st_nxt = st_r;
    st_nxt.rd_sync = {st_r.rd_sync[1:0], ~i_cs_n & ~i_rd_n};
    st_nxt.wr_sync = {st_r.wr_sync[1:0], ~i_cs_n & ~i_wr_n};
    st_nxt.oe      = st_r.rd_sync[1];
    st_nxt.addr_sync = {st_r.addr_sync[0], i_addr};
    st_nxt.data_sync = {st_r.data_sync[0], i_data};
    st_nxt.rd_pend = rd_edge;
    if (rd_edge)
      st_nxt.bus.addr = host_addr;

    // read data one cycle after capture so the enable word is ready
    if (st_r.rd_pend)
    begin
      if (rd_grp_hit)
      begin
        li = offset4(st_r.bus.addr, stats_irq_pkg::GRP_OFS);
        rv = {11'h000, grp_flags[li[2:0]*5 +: 5]};
      end
      else if (rd_alarm_hit)
      begin
        li = offset4(st_r.bus.addr, stats_irq_pkg::ALARM_OFS);
        rv[stats_irq_pkg::SYNC_END_BIT -: 2] = alarm_flags[li*2 +: 2];
        if (li == 4'h0)
          rv[stats_irq_pkg::GRP_PEND_BIT] = |grp_flags;
      end
      else if (rd_en_hit)
        rv = {4'h0, en_rdata};
      else
      begin
        unique case (st_r.bus.addr)
          stats_irq_pkg::TOP_OFS:
            rv = {8'h00, st_r.cnt_read[31:24]};
          stats_irq_pkg::MID_OFS:
            rv = st_r.cnt_read[23:8];
          stats_irq_pkg::SEL_OFS:
            rv = {7'h00, st_r.sel};
          stats_irq_pkg::MASTER_OFS:
            rv = st_r.master_mask;
          stats_irq_pkg::TC_MASK_OFS:
            rv = st_r.tc_mask;
          stats_irq_pkg::CMD_OFS:
          begin
            rv[stats_irq_pkg::CMD_DONE_BIT] = st_r.done;
            rv[stats_irq_pkg::CMD_DIR_BIT]  = st_r.cmd_dir;
            rv[1:0] = st_r.cmd_code;
          end
          default:
            rv = stats_irq_pkg::REG_RESET;
        endcase
      end
      st_nxt.dout = rv;
    end

    // byte and selector writes only park values
    if (wr_edge)
    begin
      unique case (host_addr)
        stats_irq_pkg::TOP_OFS:
          st_nxt.top_hold = host_data[7:0];
        stats_irq_pkg::MID_OFS:
          st_nxt.mid_hold = host_data;
        stats_irq_pkg::SEL_OFS:
          st_nxt.sel = host_data[stats_irq_pkg::SEL_W-1:0];
        stats_irq_pkg::MASTER_OFS:
          st_nxt.master_mask = host_data;
        stats_irq_pkg::TC_MASK_OFS:
          st_nxt.tc_mask = host_data;
        stats_irq_pkg::CMD_OFS:
        begin
          st_nxt.cmd_dir  = host_data[stats_irq_pkg::CMD_DIR_BIT];
          st_nxt.cmd_code = host_data[1:0];
          // a command while one is in flight is dropped
          if (host_data[1:0] == stats_irq_pkg::CMD_XFER && !st_r.cnt.req)
          begin
            st_nxt.done      = 1'b0;
            st_nxt.cnt.req   = 1'b1;
            st_nxt.cnt.wr    = host_data[stats_irq_pkg::CMD_DIR_BIT];
            st_nxt.cnt.kind  = st_r.sel[8:5];
            st_nxt.cnt.is_group = st_r.sel[4];
            st_nxt.cnt.index = st_r.sel[3:0];
            st_nxt.cnt.wdata = {st_r.top_hold, st_r.mid_hold, 8'h00};
          end
        end
        default:
          st_nxt.cnt = st_nxt.cnt;
      endcase
    end

    if (st_r.cnt.req && i_cnt_ack)
    begin
      st_nxt.cnt.req = 1'b0;
      st_nxt.done    = 1'b1;
      if (!st_r.cnt.wr)
        st_nxt.cnt_read = i_cnt_rdata;
    end

    st_nxt.irq_n = ~|(link_src & st_r.master_mask);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r       <= '0;
      st_r.done  <= 1'b1;
      st_r.irq_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign o_data    = st_r.dout;
  assign o_data_oe = st_r.oe;
  assign o_irq_n   = st_r.irq_n;
  assign o_cnt     = st_r.cnt;
endmodule : stats_counter_access_irq
`default_nettype wire

/* hw/stats_irq_pkg.sv */
// Purpose: shared constants and carriers of the statistics/interrupt bank
// Assumes: 16-bit host data, 12-bit register index, 16 links, 8 groups
// Notes:   offsets are word indices on the host port
`default_nettype none
package stats_irq_pkg;
  localparam int unsigned N_LINKS  = 16;
  localparam int unsigned N_GROUPS = 8;
  localparam int unsigned GRP_W    = 5;
  localparam int unsigned EN_W     = 12;

  localparam logic [11:0] CMD_OFS       = 12'h400;
  localparam logic [11:0] GRP_OFS       = 12'h420;
  localparam logic [11:0] TOP_OFS       = 12'h430;
  localparam logic [11:0] MID_OFS       = 12'h431;
  localparam logic [11:0] SEL_OFS       = 12'h432;
  localparam logic [11:0] MASTER_OFS    = 12'h433;
  localparam logic [11:0] TC_MASK_OFS   = 12'h434;
  localparam logic [11:0] ALARM_OFS     = 12'h435;
  localparam logic [11:0] LINK_EN_OFS   = 12'h445;

  localparam int unsigned GRP_FIFO_BIT  = 4;
  localparam int unsigned SYNC_END_BIT  = 11;
  localparam int unsigned FRAME_END_BIT = 10;
  localparam int unsigned GRP_PEND_BIT  = 8;
  localparam int unsigned CMD_DONE_BIT  = 7;
  localparam int unsigned CMD_DIR_BIT   = 2;
  localparam int unsigned SEL_KIND_LSB  = 5;
  localparam int unsigned SEL_W         = 9;

  localparam logic [1:0]  CMD_XFER      = 2'h1;
  localparam logic [15:0] REG_RESET     = 16'h0000;

  typedef enum logic [3:0] {
    CNT_RX_BAD_ICP = 4'h0, CNT_RX_HEC  = 4'h1, CNT_RX_IDLE  = 4'h2,
    CNT_RX_TOTAL   = 4'h3, CNT_TX_ICP  = 4'h4, CNT_TX_STUFF = 4'h5,
    CNT_TX_IDLE    = 4'h6, CNT_TX_TOTAL = 4'h7, CNT_IN_HEC  = 4'h8,
    CNT_IN_UNASSIGNED = 4'h9, CNT_IN_IDLE = 4'ha, CNT_IN_ALL = 4'hb
  } counter_kind_e;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [3:0]  kind;
    logic        is_group;
    logic [3:0]  index;
    logic [31:0] wdata;
  } cnt_req_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
  } bus_word_s;
endpackage : stats_irq_pkg
`default_nettype wire

/* hw/sticky_flag_bank.sv */
// Purpose: bank of hardware-set flags cleared by writing zero
// Assumes: set pulses are on the same clock
// Notes:   a set in the clearing cycle wins
`default_nettype none
module sticky_flag_bank #(
  parameter int unsigned N = 8,
  parameter int unsigned W = 5
) (
  input  wire logic           i_clk,
  input  wire logic           i_arst_n,
  input  wire logic [N*W-1:0] i_set,
  input  wire logic           i_wr,
  input  wire logic [3:0]     i_idx,
  input  wire logic [W-1:0]   i_wdata,
  output var  logic [N*W-1:0] o_flags
);
  typedef struct packed {
    logic [N*W-1:0] flags;
  } bank_s;

  bank_s st_r;
  bank_s st_nxt;

  function automatic logic [N*W-1:0] clear_mask(input logic [3:0] idx,
                                                 input logic [W-1:0] wd);
    logic [N*W-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++)
    begin
      if (idx == 4'(i))
        m[i*W +: W] = ~wd;
    end
    return m;
  endfunction : clear_mask

  always_comb
  begin
    st_nxt = st_r;
    if (i_wr)
      st_nxt.flags = st_r.flags & ~clear_mask(i_idx, i_wdata);
    st_nxt.flags = st_nxt.flags | i_set;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_flags = st_r.flags;
endmodule : sticky_flag_bank
`default_nettype wire

/* tb/cnt_store.sv */
// Purpose: behavioural counter store behind the request port
// Assumes: request holds until ack
// Notes:   answers after 1 to 4 cycles; data scrambled off ack
`default_nettype none
module cnt_store (
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire stats_irq_pkg::cnt_req_s i_cnt,
  output var  logic                    o_ack,
  output var  logic [31:0]             o_rdata,
  output var  logic [8:0]              o_key,
  output var  logic [31:0]             o_wdata,
  output var  int                      o_reqs
);
  logic [31:0] mem [512];
  int          pseed;
  initial
  begin
    pseed = 32'hd7e7;
    o_ack = 1'b0;
    o_rdata = 32'h0000_0000;
    o_key = 9'h000;
    o_wdata = 32'h0000_0000;
    o_reqs = 0;
    forever
    begin
      @(posedge i_clk);
      if (i_arst_n && i_cnt.req)
      begin
        repeat ($random(pseed) & 3) @(posedge i_clk);
        o_ack <= 1'b1;
        o_key <= {i_cnt.kind, i_cnt.is_group, i_cnt.index};
        o_wdata <= i_cnt.wdata;
        o_rdata <= mem[{i_cnt.kind, i_cnt.is_group, i_cnt.index}];
        if (i_cnt.wr)
          mem[{i_cnt.kind, i_cnt.is_group, i_cnt.index}] <= i_cnt.wdata;
        o_reqs <= o_reqs + 1;
        @(posedge i_clk);
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
      end
    end
  end
endmodule : cnt_store
`default_nettype wire

/* tb/stats_irq_asserts.sv */
// Purpose: port checks of the statistics/interrupt bank
// Assumes: host strobes last at least 6 cycles
// Notes:   age counters bound the cause of irq and request edges
`default_nettype none
module stats_irq_asserts (
  input wire logic                    i_clk,
  input wire logic                    i_arst_n,
  input wire logic                    i_cs_n,
  input wire logic                    i_rd_n,
  input wire logic                    i_wr_n,
  input wire logic [15:0]             o_data,
  input wire logic                    o_data_oe,
  input wire logic                    o_irq_n,
  input wire logic [15:0]             i_tc_ovf_pending,
  input wire stats_irq_pkg::cnt_req_s o_cnt,
  input wire logic                    i_cnt_ack
);
  logic [3:0]  wr_age_r;
  logic [3:0]  tc_age_r;
  logic [15:0] tc_q_r;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // saturate so a stale write never looks recent
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_age_r <= 4'hf;
      tc_age_r <= 4'hf;
      tc_q_r   <= 16'h0000;
    end
    else
    begin
      wr_age_r <= (!i_cs_n && !i_wr_n) ? 4'h0
                  : wr_age_r + 4'(wr_age_r != 4'hf);
      tc_age_r <= (tc_q_r != i_tc_ovf_pending) ? 4'h0
                  : tc_age_r + 4'(tc_age_r != 4'hf);
      tc_q_r   <= i_tc_ovf_pending;
    end
  end
  property p_req_hold;
    o_cnt.req && !i_cnt_ack |=> o_cnt.req && $stable(o_cnt);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("counter request changed before ack");
  property p_req_done;
    o_cnt.req && i_cnt_ack |=> !o_cnt.req;
  endproperty
  a_req_done: assert property (p_req_done)
    else $error("counter request held after ack");
  property p_req_start;
    $rose(o_cnt.req) |-> wr_age_r < 4'h8;
  endproperty
  a_req_start: assert property (p_req_start)
    else $error("counter request without host write");
  property p_wdata;
    o_cnt.req |-> o_cnt.wdata[7:0] == 8'h00;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("counter write byte 0 not zero");
  property p_sel;
    o_cnt.req |-> o_cnt.is_group == o_cnt.kind[3];
  endproperty
  a_sel: assert property (p_sel)
    else $error("selector group bit mismatch");
  property p_oe_rise;
    (!i_cs_n && !i_rd_n) [*5] |-> o_data_oe;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data not driven during read");
  property p_oe_fall;
    (i_cs_n || i_rd_n) [*4] |-> !o_data_oe;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("data driven without read");
  property p_data_hold;
    i_rd_n [*8] |-> $stable(o_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data changed without read");
  property p_irq_rise;
    $rose(o_irq_n) |-> wr_age_r < 4'h8 || tc_age_r < 4'h4;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq released without clear or mask");
  c_xfer: cover property (o_cnt.req && i_cnt_ack);
  c_irq: cover property ($fell(o_irq_n));
  c_read: cover property ($rose(o_data_oe));
endmodule : stats_irq_asserts
bind stats_counter_access_irq stats_irq_asserts u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_wr_n(i_wr_n), .o_data(o_data), .o_data_oe(o_data_oe),
  .o_irq_n(o_irq_n), .i_tc_ovf_pending(i_tc_ovf_pending),
  .o_cnt(o_cnt), .i_cnt_ack(i_cnt_ack)
);
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench of the statistics/interrupt bank
// Assumes: strobes held 7 cycles, 5 idle cycles between
// Notes:   counter values modelled in an associative array
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        arst_n;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic [11:0] addr;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic        oe;
  logic        irq_n;
  logic [39:0] grp_set;
  logic [15:0] sync_end;
  logic [15:0] frame_end;
  logic [15:0] tc_pend;
  logic        ack;
  logic [31:0] crdata;
  logic [8:0]  key;
  logic [31:0] seen_w;
  int          reqs;
  int          fails;
  int          checked;
  int          seed;
  int          exp_mem [int];
  stats_irq_pkg::cnt_req_s cnt;
  stats_counter_access_irq dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_addr(addr), .i_data(wdat), .o_data(rdat),
    .o_data_oe(oe), .o_irq_n(irq_n), .i_grp_ovf_set(grp_set),
    .i_delay_sync_loss_end(sync_end), .i_frame_loss_end(frame_end),
    .i_tc_ovf_pending(tc_pend), .o_cnt(cnt), .i_cnt_ack(ack),
    .i_cnt_rdata(crdata)
  );
  cnt_store u_store (
    .i_clk(clk), .i_arst_n(arst_n), .i_cnt(cnt), .o_ack(ack),
    .o_rdata(crdata), .o_key(key), .o_wdata(seen_w), .o_reqs(reqs)
  );
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    addr <= a;
    wdat <= d;
    repeat (7) @(posedge clk);
    q = rdat;
    chk("oe", oe, !w);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    wdat <= ~d;
    repeat (4) @(posedge clk);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hffff);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk($sformatf("reg %h", a), q & m, e);
  endtask : rc
  task automatic pulse(input logic [39:0] g, input logic [15:0] s);
    @(posedge clk);
    grp_set <= g;
    sync_end <= s;
    frame_end <= s;
    @(posedge clk);
    grp_set <= 40'h0;
    sync_end <= 16'h0000;
    frame_end <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    int          g;
    int          n;
    int          r;
    logic [8:0]  sel;
    logic [15:0] top;
    logic [15:0] mid;
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 12'h000;
    wdat = 16'h0000;
    grp_set = 40'h0;
    sync_end = 16'h0000;
    frame_end = 16'h0000;
    tc_pend = 16'h0000;
    arst_n = 1'b0;
    seed = 32'hd7e7;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 12'h420; a < 12'h436; a++)
      rc(12'(a), 16'h0000);
    rc(stats_irq_pkg::CMD_OFS, 16'h0080, 16'h0080);
    for (int b = 0; b < 5; b++)
    begin
      g = {$random(seed)} % 8;
      pulse(40'h1 << (g * 5 + b), 16'h0000);
      rc(stats_irq_pkg::GRP_OFS + 12'(g), 16'h1 << b);
      wr(stats_irq_pkg::GRP_OFS + 12'(g), 16'hffff);
      rc(stats_irq_pkg::GRP_OFS + 12'(g), 16'h1 << b);
      wr(stats_irq_pkg::GRP_OFS + 12'(g), 16'h0000);
      rc(stats_irq_pkg::GRP_OFS + 12'(g), 16'h0000);
    end
    n = 1 + {$random(seed)} % 15;
    pulse(40'h0, 16'h1 << n);
    rc(stats_irq_pkg::ALARM_OFS + 12'(n), 16'h0c00);
    chk("irq_n", irq_n, 1'b1);
    wr(stats_irq_pkg::LINK_EN_OFS + 12'(n), 16'h0800);
    rc(stats_irq_pkg::LINK_EN_OFS + 12'(n), 16'h0800);
    wr(stats_irq_pkg::MASTER_OFS, 16'h1 << n);
    chk("irq_n", irq_n, 1'b0);
    rc(stats_irq_pkg::MASTER_OFS, 16'h1 << n);
    wr(stats_irq_pkg::MASTER_OFS, 16'h0000);
    chk("irq_n", irq_n, 1'b1);
    wr(stats_irq_pkg::ALARM_OFS + 12'(n), 16'h0400);
    wr(stats_irq_pkg::MASTER_OFS, 16'h1 << n);
    chk("irq_n", irq_n, 1'b1);
    rc(stats_irq_pkg::ALARM_OFS + 12'(n), 16'h0400);
    @(posedge clk);
    tc_pend <= 16'h1 << n;
    repeat (3) @(posedge clk);
    chk("irq_n", irq_n, 1'b1);
    wr(stats_irq_pkg::TC_MASK_OFS, 16'h1 << n);
    chk("irq_n", irq_n, 1'b0);
    rc(stats_irq_pkg::TC_MASK_OFS, 16'h1 << n);
    @(posedge clk);
    tc_pend <= 16'h0000;
    repeat (3) @(posedge clk);
    chk("irq_n", irq_n, 1'b1);
    for (int k = 0; k < 12; k++)
    begin
      // only listed encodings are ever programmed
      sel = {4'(k), k > 7, k > 7 ? 4'({$random(seed)} % 8)
                                 : 4'($random(seed))};
      top = 16'($random(seed));
      mid = 16'($random(seed));
      r = reqs;
      wr(stats_irq_pkg::SEL_OFS, {7'h00, sel});
      wr(stats_irq_pkg::TOP_OFS, top);
      wr(stats_irq_pkg::MID_OFS, mid);
      chk("reqs", reqs, r);
      wr(stats_irq_pkg::CMD_OFS, 16'h0005);
      chk("reqs", reqs, r + 1);
      chk("key", key, sel);
      exp_mem[sel] = {top[7:0], mid, 8'h00};
      chk("wdata", seen_w, exp_mem[sel]);
      wr(stats_irq_pkg::TOP_OFS, ~top);
      wr(stats_irq_pkg::CMD_OFS, 16'h0001);
      rc(stats_irq_pkg::TOP_OFS, {8'h00, exp_mem[sel][31:24]});
      rc(stats_irq_pkg::MID_OFS, exp_mem[sel][23:8]);
      wr(stats_irq_pkg::CMD_OFS, 16'h0001);
      rc(stats_irq_pkg::TOP_OFS, {8'h00, exp_mem[sel][31:24]});
      rc(stats_irq_pkg::CMD_OFS, 16'h0080, 16'h0080);
    end
    r = reqs;
    wr(stats_irq_pkg::CMD_OFS, 16'h0002);
    wr(stats_irq_pkg::CMD_OFS, 16'h0003);
    chk("reqs", reqs, r);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
